//--- hw/lsca_pkg.sv
package lsca_pkg;

    // --------------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] LSCA_OFS_CTRL = 8'h00;
    localparam logic [7:0] LSCA_OFS_ADAPT = 8'h04;
    localparam logic [7:0] LSCA_OFS_LOWVEL = 8'h08;
    localparam logic [7:0] LSCA_OFS_PWMVEL = 8'h0C;
    localparam logic [7:0] LSCA_OFS_STATUS = 8'h10;
    localparam logic [7:0] LSCA_OFS_IND = 8'h14;
    localparam logic [7:0] LSCA_OFS_PHASE = 8'h18;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int LSCA_POS_AVG = 8;
    localparam int LSCA_POS_COMP = 9;
    localparam int LSCA_POS_MINCUR = 10;
    localparam int LSCA_POS_STATUS_SCALE = 16;

    // --------------------------------------------------------------------
    // Values after reset
    // --------------------------------------------------------------------
    localparam logic [10:0] LSCA_RST_CTRL = 11'h000;
    localparam logic [19:0] LSCA_RST_LOWVEL = 20'h00000;
    localparam logic [19:0] LSCA_RST_PWMVEL = 20'h00000;
    localparam logic [4:0] LSCA_RST_RUN = 5'h1F;

    // --------------------------------------------------------------------
    // Counts
    // --------------------------------------------------------------------
    localparam logic [5:0] LSCA_DEC_CNT0 = 6'h20;
    localparam logic [5:0] LSCA_DEC_CNT1 = 6'h08;
    localparam logic [5:0] LSCA_DEC_CNT2 = 6'h02;
    localparam logic [5:0] LSCA_DEC_CNT3 = 6'h01;
    localparam int LSCA_THR_SHIFT = 5;
    localparam int LSCA_MEAS_COUNT = 4;

    // --------------------------------------------------------------------
    // Carrier types
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] index;
        logic [7:0] value;
    } lsca_meas_type;

    typedef struct packed {
        logic [4:0] runCurrentScale;
        logic [1:0] adaptDecrementRate;
        logic [1:0] adaptIncrementStep;
        logic [3:0] adaptHighMargin;
        logic [3:0] adaptLowThreshold;
    } lsca_adapt_type;

    localparam lsca_adapt_type LSCA_RST_ADAPT = '{LSCA_RST_RUN, 2'h0, 2'h0, 4'h0, 4'h0};

endpackage

//--- hw/lsca_vm_load_calc.sv
`timescale 1ns/1ps

module lsca_vm_load_calc
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic measValid,
    input wire lsca_pkg::lsca_meas_type meas,
    input wire logic vmLoadAverageOn,
    output logic [8:0] vmLoadValue,
    output logic vmLoadValid,
    output logic [7:0] vmLoadInd [lsca_pkg::LSCA_MEAS_COUNT]
);

    logic [9:0] sumNext;
    logic [7:0] indNext [lsca_pkg::LSCA_MEAS_COUNT];

    // --------------------------------------------------------------------
    // Individual measurements
    // --------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < lsca_pkg::LSCA_MEAS_COUNT; g++)
        begin : gInd
            // Unfiltered: slot 0 carries every transition
            always_comb
            begin
                indNext[g] = vmLoadInd[g];
                if (measValid && vmLoadAverageOn && meas.index == 2'(g))
                    indNext[g] = meas.value;
                else if (measValid && !vmLoadAverageOn && g == 0)
                    indNext[g] = meas.value;
            end

            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    vmLoadInd[g] <= 8'h00;
                else
                    vmLoadInd[g] <= indNext[g];
            end
        end
    endgenerate

    // Sum of four, halved: average with one extra bit
    assign sumNext = {2'h0, indNext[0]} + {2'h0, indNext[1]} + {2'h0, indNext[2]}
        + {2'h0, indNext[3]};

    // --------------------------------------------------------------------
    // Load result, refreshed once per fullstep
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vmLoadValue <= 9'h000;
            vmLoadValid <= 1'b0;
        end
        else
        begin
            vmLoadValid <= measValid;
            if (measValid && vmLoadAverageOn)
                vmLoadValue <= sumNext[9:1];
            else if (measValid)
                vmLoadValue <= {meas.value, 1'b0};
        end
    end

endmodule // lsca_vm_load_calc

//--- hw/lsca_load_stall_current_adapt.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - Stall when load below doubled 8-bit threshold
// - Load result spans 0 to 510
// - Load result computed regardless of mode
// - Result adds one precision bit to measurements
// - Four 8-bit measurements, one per coil transition
// - Slots separate only when averaging; else slot 0
// - Single measurement or average of last four
// - Average refreshed each fullstep, quarter weight each
// - Unfiltered result fully replaced each fullstep
// - Store phase offset, apply and remove on switches
// - Pulse stall output when load falls below threshold
// - Stall only in voltage mode within velocity window
// - Adaptation uses load of active chopper mode
// - Low field zero disables; else threshold field times 32
// - High threshold is low plus margin plus one, times 32
// - Increment step 1, 2, 4 or 8
// - Decrement after 32, 8, 2 or 1 samples
// - Minimum current half or quarter of run current
// - Actual scale 0 to 31, capped at run current

module lsca_load_stall_current_adapt
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic measValid,
    input wire lsca_pkg::lsca_meas_type meas,
    input wire logic voltageMode,
    input wire logic [19:0] measuredStepInterval,
    input wire logic [9:0] cmLoadValue,
    input wire logic cmLoadValid,
    output logic stallPulse,
    output logic [4:0] currentScale,
    output logic [9:0] phaseCorrect,
    output logic phaseCorrectValid
);

    logic [7:0] vmStallThreshold_reg;
    logic vmLoadAverageOn_reg;
    logic phaseLagCompensate_reg;
    logic adaptMinQuarter_reg;
    lsca_pkg::lsca_adapt_type adapt_reg;
    logic [19:0] adaptLowVelocityLimit_reg;
    logic [19:0] pwmModeVelocityLimit_reg;
    logic [8:0] phaseOffset_reg;
    logic voltageMode_reg;
    logic [5:0] decCount_reg;
    logic [8:0] vmLoadValue;
    logic vmLoadValid;
    logic [7:0] vmLoadInd [lsca_pkg::LSCA_MEAS_COUNT];
    logic stallEnable;
    logic [9:0] vmStallLimit;
    logic adaptSample;
    logic [9:0] adaptLoad;
    logic [9:0] lowLimit;
    logic [9:0] highLimit;
    logic [5:0] incSum;
    logic [5:0] decNeed;
    logic [4:0] minScale;
    logic [4:0] scale_next;
    logic [5:0] decCount_next;
    logic [31:0] rdata_next;
    logic err_next;

    // --------------------------------------------------------------------
    // Voltage-mode load measurement
    // --------------------------------------------------------------------
    lsca_vm_load_calc lsca_vm_load_calc_inst
    (
        .clk(clk),
        .nrst(nrst),
        .measValid(measValid),
        .meas(meas),
        .vmLoadAverageOn(vmLoadAverageOn_reg),
        .vmLoadValue(vmLoadValue),
        .vmLoadValid(vmLoadValid),
        .vmLoadInd(vmLoadInd)
    );

    // --------------------------------------------------------------------
    // APB register writes
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {adaptMinQuarter_reg, phaseLagCompensate_reg, vmLoadAverageOn_reg,
                vmStallThreshold_reg} <= lsca_pkg::LSCA_RST_CTRL;
            adapt_reg <= lsca_pkg::LSCA_RST_ADAPT;
            adaptLowVelocityLimit_reg <= lsca_pkg::LSCA_RST_LOWVEL;
            pwmModeVelocityLimit_reg <= lsca_pkg::LSCA_RST_PWMVEL;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == lsca_pkg::LSCA_OFS_CTRL)
            begin
                vmStallThreshold_reg <= pwdata[7:0];
                vmLoadAverageOn_reg <= pwdata[lsca_pkg::LSCA_POS_AVG];
                phaseLagCompensate_reg <= pwdata[lsca_pkg::LSCA_POS_COMP];
                adaptMinQuarter_reg <= pwdata[lsca_pkg::LSCA_POS_MINCUR];
            end
            else if (paddr == lsca_pkg::LSCA_OFS_ADAPT)
                adapt_reg <= pwdata[16:0];
            else if (paddr == lsca_pkg::LSCA_OFS_LOWVEL)
                adaptLowVelocityLimit_reg <= pwdata[19:0];
            else if (paddr == lsca_pkg::LSCA_OFS_PWMVEL)
                pwmModeVelocityLimit_reg <= pwdata[19:0];
        end
    end

    // --------------------------------------------------------------------
    // APB read decode
    // --------------------------------------------------------------------
    always_comb
    begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        if (paddr == lsca_pkg::LSCA_OFS_CTRL)
            rdata_next[10:0] = {adaptMinQuarter_reg, phaseLagCompensate_reg,
                vmLoadAverageOn_reg, vmStallThreshold_reg};
        else if (paddr == lsca_pkg::LSCA_OFS_ADAPT)
            rdata_next[16:0] = adapt_reg;
        else if (paddr == lsca_pkg::LSCA_OFS_LOWVEL)
            rdata_next[19:0] = adaptLowVelocityLimit_reg;
        else if (paddr == lsca_pkg::LSCA_OFS_PWMVEL)
            rdata_next[19:0] = pwmModeVelocityLimit_reg;
        else if (paddr == lsca_pkg::LSCA_OFS_STATUS)
        begin
            rdata_next[8:0] = vmLoadValue;
            rdata_next[lsca_pkg::LSCA_POS_STATUS_SCALE +: 5] = currentScale;
        end
        else if (paddr == lsca_pkg::LSCA_OFS_IND)
            rdata_next = {vmLoadInd[3], vmLoadInd[2], vmLoadInd[1], vmLoadInd[0]};
        else if (paddr == lsca_pkg::LSCA_OFS_PHASE)
            rdata_next[8:0] = phaseOffset_reg;
        else
            err_next = 1'b1;
    end

    // Zero-wait slave: answer prepared in the setup cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && err_next;
            prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h00000000;
        end
    end

    // --------------------------------------------------------------------
    // Stall detection
    // --------------------------------------------------------------------
    assign vmStallLimit = {1'b0, vmStallThreshold_reg, 1'b0};
    assign stallEnable = voltageMode && (adaptLowVelocityLimit_reg >= measuredStepInterval)
        && (measuredStepInterval > pwmModeVelocityLimit_reg);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stallPulse <= 1'b0;
        else
            stallPulse <= vmLoadValid && stallEnable
                && ({1'b0, vmLoadValue} < vmStallLimit);
    end

    // --------------------------------------------------------------------
    // Phase offset memory
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            voltageMode_reg <= 1'b0;
            phaseOffset_reg <= 9'h000;
            phaseCorrect <= 10'h000;
            phaseCorrectValid <= 1'b0;
        end
        else
        begin
            voltageMode_reg <= voltageMode;
            phaseCorrectValid <= 1'b0;
            if (phaseLagCompensate_reg && voltageMode_reg && !voltageMode)
            begin
                phaseOffset_reg <= vmLoadValue;
                phaseCorrect <= {1'b0, vmLoadValue};
                phaseCorrectValid <= 1'b1;
            end
            else if (phaseLagCompensate_reg && !voltageMode_reg && voltageMode)
            begin
                phaseCorrect <= 10'h000 - {1'b0, phaseOffset_reg};
                phaseCorrectValid <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------------
    // Load-adaptive current scale
    // --------------------------------------------------------------------
    assign adaptSample = voltageMode ? vmLoadValid : cmLoadValid;
    assign adaptLoad = voltageMode ? {1'b0, vmLoadValue} : cmLoadValue;
    assign lowLimit = {2'h0, adapt_reg.adaptLowThreshold, 4'h0} << 1;
    assign highLimit = {({1'b0, adapt_reg.adaptLowThreshold} + {1'b0, adapt_reg.adaptHighMargin}
        + 5'h01), 5'h00};
    assign incSum = {1'b0, currentScale} + (6'h01 << adapt_reg.adaptIncrementStep);
    assign minScale = adaptMinQuarter_reg ? (adapt_reg.runCurrentScale >> 2)
        : (adapt_reg.runCurrentScale >> 1);

    always_comb
    begin
        case (adapt_reg.adaptDecrementRate)
            2'h0: decNeed = lsca_pkg::LSCA_DEC_CNT0;
            2'h1: decNeed = lsca_pkg::LSCA_DEC_CNT1;
            2'h2: decNeed = lsca_pkg::LSCA_DEC_CNT2;
            default: decNeed = lsca_pkg::LSCA_DEC_CNT3;
        endcase
    end

    always_comb
    begin
        scale_next = currentScale;
        decCount_next = decCount_reg;
        if (adapt_reg.adaptLowThreshold == 4'h0)
        begin
            scale_next = adapt_reg.runCurrentScale;
            decCount_next = 6'h00;
        end
        else if (adaptSample && adaptLoad < lowLimit)
        begin
            decCount_next = 6'h00;
            if (incSum > {1'b0, adapt_reg.runCurrentScale})
                scale_next = adapt_reg.runCurrentScale;
            else
                scale_next = incSum[4:0];
        end
        else if (adaptSample && adaptLoad >= highLimit)
        begin
            if (decCount_reg + 6'h01 >= decNeed)
            begin
                decCount_next = 6'h00;
                if (currentScale > minScale)
                    scale_next = currentScale - 5'h01;
            end
            else
                decCount_next = decCount_reg + 6'h01;
        end
        else if (adaptSample)
            decCount_next = 6'h00;
        if (scale_next > adapt_reg.runCurrentScale)
            scale_next = adapt_reg.runCurrentScale;
        else if (adapt_reg.adaptLowThreshold != 4'h0 && scale_next < minScale)
            scale_next = minScale;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            currentScale <= 5'h00;
            decCount_reg <= 6'h00;
        end
        else
        begin
            currentScale <= scale_next;
            decCount_reg <= decCount_next;
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    a_stall_fires: assert property (@(posedge clk) disable iff (!nrst)
        (vmLoadValid && stallEnable && {1'b0, vmLoadValue} < vmStallLimit) |=> stallPulse)
        else $error("stall pulse missing");
    a_stall_cause: assert property (@(posedge clk) disable iff (!nrst)
        stallPulse |-> $past(vmLoadValid) && $past(voltageMode))
        else $error("stall pulse without cause");
    a_stall_single: assert property (@(posedge clk) disable iff (!nrst)
        (stallPulse && !$past(measValid)) |=> !stallPulse)
        else $error("stall pulse too long");
    a_load_range: assert property (@(posedge clk) disable iff (!nrst)
        vmLoadValue <= 9'h1FE)
        else $error("load result out of range");
    a_unfilt_load: assert property (@(posedge clk) disable iff (!nrst)
        (measValid && !vmLoadAverageOn_reg) |=> vmLoadValue == {$past(meas.value), 1'b0})
        else $error("unfiltered load wrong");
    a_scale_bound: assert property (@(posedge clk) disable iff (!nrst)
        (adapt_reg == $past(adapt_reg) && $past(adapt_reg) == $past(adapt_reg, 2))
        |-> currentScale <= adapt_reg.runCurrentScale)
        else $error("scale above run current");
    a_adapt_off: assert property (@(posedge clk) disable iff (!nrst)
        (adapt_reg.adaptLowThreshold == 4'h0 && !(psel && penable && pwrite))
        |=> currentScale == $past(adapt_reg.runCurrentScale))
        else $error("adaptation not disabled");
    a_phase_store: assert property (@(posedge clk) disable iff (!nrst)
        (phaseLagCompensate_reg && voltageMode_reg && !voltageMode)
        |=> phaseCorrectValid && phaseOffset_reg == $past(vmLoadValue))
        else $error("phase offset not stored");
    a_apb_ready: assert property (@(posedge clk) disable iff (!nrst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready timing wrong");

    c_stall: cover property (@(posedge clk) disable iff (!nrst) stallPulse);
    c_raise: cover property (@(posedge clk) disable iff (!nrst)
        currentScale > $past(currentScale));
    c_lower: cover property (@(posedge clk) disable iff (!nrst)
        currentScale < $past(currentScale));
    c_phase: cover property (@(posedge clk) disable iff (!nrst) phaseCorrectValid);

endmodule // lsca_load_stall_current_adapt

//--- test/lsca_motion_ctrl.sv
`timescale 1ns/1ps

// ----------------------------------------
// Motion controller watching stall pulses
// ----------------------------------------
module lsca_motion_ctrl
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic stallPulse,
    input wire logic restart,
    output logic stopMotor,
    output logic [7:0] stallCount
);
    // Stop on a single pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stopMotor <= 1'h0;
        else if (stallPulse)
            stopMotor <= 1'h1;
        else if (restart)
            stopMotor <= 1'h0;
    end

    // Pulse count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stallCount <= 8'h00;
        else if (stallPulse)
            stallCount <= stallCount + 8'h01;
    end
endmodule // lsca_motion_ctrl

//--- test/lsca_load_stall_current_adapt_bench.sv
`timescale 1ns/1ps

// ----------------------------------------
// Bench
// ----------------------------------------
module lsca_load_stall_current_adapt_bench;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic measValid = 1'h0;
    lsca_pkg::lsca_meas_type meas = '0;
    logic voltageMode = 1'h1;
    logic [19:0] measuredStepInterval = 20'h00032;
    logic [9:0] cmLoadValue = 10'h000;
    logic cmLoadValid = 1'h0;
    logic restart = 1'h0;
    logic stallPulse;
    logic stopMotor;
    logic phaseCorrectValid;
    logic [4:0] currentScale;
    logic [9:0] phaseCorrect;
    logic [7:0] stallCount;
    logic tabVm [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    logic [19:0] tabIv [6] = '{20'h32, 20'h64, 20'h65, 20'h0A, 20'h0B, 20'h32};
    logic tabEx [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    int err_total = 0;
    int tests_run = 0;

    always #50 clk = ~clk;

    lsca_load_stall_current_adapt lsca_load_stall_current_adapt_inst
    (
        .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .measValid, .meas, .voltageMode, .measuredStepInterval, .cmLoadValue, .cmLoadValid,
        .stallPulse, .currentScale, .phaseCorrect, .phaseCorrectValid
    );

    lsca_motion_ctrl lsca_motion_ctrl_inst
    (
        .clk, .nrst, .stallPulse, .restart, .stopMotor, .stallCount
    );

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk("register", e, rd & m);
    endtask

    task send(input logic [1:0] i, input logic [7:0] v, input logic e);
        @(posedge clk);
        measValid <= 1'h1;
        meas <= '{i, v};
        restart <= 1'h1;
        @(posedge clk);
        measValid <= 1'h0;
        restart <= 1'h0;
        @(posedge clk);
        #1;
        chk("stallPulse", {31'h0, e}, {31'h0, stallPulse});
        @(posedge clk);
        #1;
        chk("pulseEnd", {30'h0, 1'h0, e}, {30'h0, stallPulse, stopMotor});
    endtask

    task cm(input logic [9:0] v);
        @(posedge clk);
        cmLoadValid <= 1'h1;
        cmLoadValue <= v;
        @(posedge clk);
        cmLoadValid <= 1'h0;
        @(posedge clk);
        #1;
    endtask

    task sc(input logic [4:0] e);
        chk("currentScale", {27'h0, e}, {27'h0, currentScale});
    endtask

    task pw(input logic [9:0] e);
        int n;
        n = 0;
        while (phaseCorrectValid !== 1'h1 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("phaseCorrectValid", 32'h1, {31'h0, phaseCorrectValid});
        chk("phaseCorrect", {22'h0, e}, {22'h0, phaseCorrect});
    endtask

    task t_reset;
        sc(5'h1F);
        rchk(lsca_pkg::LSCA_OFS_ADAPT, 32'hFFFFFFFF, 32'h0001F000);
        rchk(lsca_pkg::LSCA_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1FF, 32'h0);
        apb(1'h0, 8'h1C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("reset test done");
    endtask

    task t_window;
        logic [7:0] v;
        apb(1'h1, lsca_pkg::LSCA_OFS_LOWVEL, 32'h64);
        apb(1'h1, lsca_pkg::LSCA_OFS_PWMVEL, 32'h0A);
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h40);
        for (int i = 0; i < 6; i++)
        begin
            v = 8'h30 + 8'(i);
            @(posedge clk);
            voltageMode <= tabVm[i];
            measuredStepInterval <= tabIv[i];
            send(2'(i), v, tabEx[i]);
            rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1FF, {23'h0, v, 1'h0});
            rchk(lsca_pkg::LSCA_OFS_IND, 32'hFF, {24'h0, v});
        end
        @(posedge clk);
        voltageMode <= 1'h1;
        measuredStepInterval <= 20'h00032;
        send(2'h0, 8'h40, 1'h0);
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'hFF);
        send(2'h0, 8'hFF, 1'h0);
        rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1FF, 32'h1FE);
        send(2'h0, 8'hFE, 1'h1);
        chk("stallCount", 32'h4, {24'h0, stallCount});
        $display("window test done");
    endtask

    task t_filter;
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h100);
        for (int i = 0; i < 4; i++)
            send(2'(i), 8'h0A * 8'(i + 1), 1'h0);
        rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1FF, 32'h32);
        rchk(lsca_pkg::LSCA_OFS_IND, 32'hFFFFFFFF, 32'h281E140A);
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h140);
        send(2'h0, 8'h32, 1'h1);
        rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1FF, 32'h46);
        $display("filter test done");
    endtask

    task t_phase;
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h200);
        send(2'h0, 8'h20, 1'h0);
        @(posedge clk);
        voltageMode <= 1'h0;
        pw(10'h040);
        rchk(lsca_pkg::LSCA_OFS_PHASE, 32'h1FF, 32'h40);
        @(posedge clk);
        voltageMode <= 1'h1;
        pw(10'h3C0);
        $display("phase test done");
    endtask

    task t_adapt;
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h0);
        @(posedge clk);
        voltageMode <= 1'h0;
        apb(1'h1, lsca_pkg::LSCA_OFS_ADAPT, 32'h10F01);
        repeat (10) cm(10'h258);
        sc(5'h08);
        rchk(lsca_pkg::LSCA_OFS_STATUS, 32'h1F0000, 32'h80000);
        apb(1'h1, lsca_pkg::LSCA_OFS_CTRL, 32'h400);
        repeat (10) cm(10'h258);
        sc(5'h04);
        cm(10'h020);
        cm(10'h03F);
        sc(5'h04);
        cm(10'h01F);
        sc(5'h0C);
        @(posedge clk);
        voltageMode <= 1'h1;
        cm(10'h000);
        sc(5'h0C);
        send(2'h0, 8'h00, 1'h0);
        sc(5'h10);
        apb(1'h1, lsca_pkg::LSCA_OFS_ADAPT, 32'h14000);
        repeat (3) @(posedge clk);
        #1;
        sc(5'h14);
        @(posedge clk);
        voltageMode <= 1'h0;
        apb(1'h1, lsca_pkg::LSCA_OFS_ADAPT, 32'h14901);
        cm(10'h258);
        sc(5'h14);
        repeat (5) cm(10'h258);
        sc(5'h11);
        cm(10'h01F);
        sc(5'h13);
        $display("adapt test done");
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        t_reset();
        t_window();
        t_filter();
        t_phase();
        t_adapt();
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule // lsca_load_stall_current_adapt_bench
